// [cirs_pkg.sv]
// package: constants for the interrupt sequencing, reset state and status word block
package cirs_pkg;
   // ==========================================================
   // reset values
   localparam logic [15:0] FLAGS_RST = 16'h0002;
   localparam logic [15:0] IP_RST = 16'hfff0;
   localparam logic [15:0] CS_RST = 16'hf000;
   localparam logic [15:0] SEG_RST = 16'h0000;
   localparam logic [15:0] MSW_RST = 16'hfff0;
   localparam logic [23:0] START_ADDR = 24'hfffff0;
   // ==========================================================
   // status word fields
   localparam int MSW_PE = 0;
   localparam int MSW_MP = 1;
   localparam int MSW_EM = 2;
   localparam int MSW_TS = 3;
   localparam logic [15:0] MSW_USED = 16'h000f;
   // ==========================================================
   // source indices in acceptance order
   localparam int SRC_EXC = 0;
   localparam int SRC_STEP = 1;
   localparam int SRC_NMI = 2;
   localparam int SRC_OVR = 3;
   localparam int SRC_IRQ = 4;
   localparam int SRC_SWI = 5;
   localparam int NUM_SRC = 6;
   localparam logic [7:0] VEC_STEP = 8'h01;
   localparam logic [7:0] VEC_NMI = 8'h02;
   localparam logic [7:0] VEC_NOCOP = 8'h07;
   localparam logic [7:0] VEC_OVR = 8'h09;
   // ==========================================================
   // timing
   localparam int STARTUP_CYCLES = 4;
   localparam int HOLD_BLOCK_CLKS = 34;
   typedef enum logic [2:0] {
      CIRS_RESET,
      CIRS_STARTUP,
      CIRS_RUN,
      CIRS_PUSH_FLAGS,
      CIRS_PUSH_CS,
      CIRS_PUSH_IP,
      CIRS_LOAD
   } cirs_state_e;
endpackage

// [cirs_prio.sv]
// fixed priority picker for pending interrupt sources
`timescale 1ns/1ps
module cirs_prio #(
   parameter int N = 6
) (
   input wire logic [N-1:0] req_in,
   output logic [N-1:0] grant_out,
   output logic any_out
);
   always_comb begin
      grant_out = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req_in[i]) begin
            grant_out = '0;
            grant_out[i] = 1'b1;
         end
      end
   end
   assign any_out = |req_in;
endmodule

// [cirs_core.sv]
// interrupt sequencing, reset state and machine status word
`timescale 1ns/1ps

module cirs_core (
   input wire logic sys_clk_in,
   input wire logic reset_n_in,
   input wire logic insn_boundary_in,
   input wire logic exc_req_in,
   input wire logic [7:0] exc_vec_in,
   input wire logic step_req_in,
   input wire logic nmi_req_in,
   input wire logic ovr_req_in,
   input wire logic maskable_irq_in,
   input wire logic [7:0] irq_vec_in,
   input wire logic swi_req_in,
   input wire logic [7:0] swi_vec_in,
   input wire logic coproc_escape_op_in,
   input wire logic wait_op_in,
   input wire logic load_status_word_instr_in,
   input wire logic [15:0] status_wdata_in,
   input wire logic store_status_word_instr_in,
   input wire logic task_switch_in,
   input wire logic [15:0] handler_ip_in,
   input wire logic [15:0] handler_cs_in,
   output logic [15:0] flags_out,
   output logic [15:0] ip_out,
   output logic [15:0] code_seg_out,
   output logic [15:0] data_seg_out,
   output logic [15:0] extra_seg_out,
   output logic [15:0] stack_seg_out,
   output logic [15:0] machine_status_word_out,
   output logic [15:0] status_rdata_out,
   output logic protected_mode_out,
   output logic exec_en_out,
   output logic [23:0] fetch_addr_out,
   output logic push_valid_out,
   output logic [15:0] push_data_out,
   output logic accept_out,
   output logic [7:0] accept_vec_out,
   output logic [5:0] accept_src_out,
   output logic coproc_trap_out,
   output logic hold_blocked_out
);
   // ==========================================================
   // reset release
   logic rst_meta_q;
   logic rst_sync_q;
   always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   wire logic rst_n = rst_sync_q;

   // ==========================================================
   // sequencer state
   cirs_pkg::cirs_state_e state_q;
   logic [7:0] start_cnt_q;
   logic [5:0] grant;
   logic any_req;
   logic [5:0] req_vec;
   logic at_boundary;
   logic [7:0] sel_vec;

   assign req_vec = {swi_req_in, maskable_irq_in & flags_out[9], ovr_req_in,
                     nmi_req_in, step_req_in, exc_req_in};
   // requests only looked at between whole instructions or between stacked entries
   assign at_boundary = (state_q == cirs_pkg::CIRS_RUN) && insn_boundary_in;

   cirs_prio #(
      .N(cirs_pkg::NUM_SRC)
   ) u_prio (
      .req_in(req_vec),
      .grant_out(grant),
      .any_out(any_req)
   );

   always_comb begin
      sel_vec = swi_vec_in;
      if (grant[cirs_pkg::SRC_EXC]) begin
         sel_vec = exc_vec_in;
      end else if (grant[cirs_pkg::SRC_STEP]) begin
         sel_vec = cirs_pkg::VEC_STEP;
      end else if (grant[cirs_pkg::SRC_NMI]) begin
         sel_vec = cirs_pkg::VEC_NMI;
      end else if (grant[cirs_pkg::SRC_OVR]) begin
         sel_vec = cirs_pkg::VEC_OVR;
      end else if (grant[cirs_pkg::SRC_IRQ]) begin
         sel_vec = irq_vec_in;
      end
   end

   logic stacking_q;
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= cirs_pkg::CIRS_STARTUP;
         start_cnt_q <= 8'h00;
         stacking_q <= 1'b0;
         accept_vec_out <= 8'h00;
         accept_src_out <= 6'h00;
      end else begin
         case (state_q)
            cirs_pkg::CIRS_STARTUP: begin
               start_cnt_q <= start_cnt_q + 8'h01;
               if (start_cnt_q == 8'(cirs_pkg::STARTUP_CYCLES - 1)) begin
                  state_q <= cirs_pkg::CIRS_RUN;
               end
            end
            cirs_pkg::CIRS_RUN: begin
               if ((at_boundary || stacking_q) && any_req) begin
                  state_q <= cirs_pkg::CIRS_PUSH_FLAGS;
                  accept_vec_out <= sel_vec;
                  accept_src_out <= grant;
               end
               stacking_q <= 1'b0;
            end
            cirs_pkg::CIRS_PUSH_FLAGS: state_q <= cirs_pkg::CIRS_PUSH_CS;
            cirs_pkg::CIRS_PUSH_CS: state_q <= cirs_pkg::CIRS_PUSH_IP;
            cirs_pkg::CIRS_PUSH_IP: state_q <= cirs_pkg::CIRS_LOAD;
            cirs_pkg::CIRS_LOAD: begin
               state_q <= cirs_pkg::CIRS_RUN;
               stacking_q <= 1'b1;
            end
            default: state_q <= cirs_pkg::CIRS_STARTUP;
         endcase
      end
   end

   assign accept_out = (state_q == cirs_pkg::CIRS_LOAD);
   // handler instructions held back while further requests are being stacked
   assign exec_en_out = (state_q == cirs_pkg::CIRS_RUN) && !(stacking_q && any_req);

   // ==========================================================
   // stack pushes
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         push_valid_out <= 1'b0;
         push_data_out <= 16'h0000;
      end else begin
         push_valid_out <= 1'b0;
         case (state_q)
            cirs_pkg::CIRS_PUSH_FLAGS: begin
               push_valid_out <= 1'b1;
               push_data_out <= flags_out;
            end
            cirs_pkg::CIRS_PUSH_CS: begin
               push_valid_out <= 1'b1;
               push_data_out <= code_seg_out;
            end
            cirs_pkg::CIRS_PUSH_IP: begin
               push_valid_out <= 1'b1;
               push_data_out <= ip_out;
            end
            default: push_data_out <= push_data_out;
         endcase
      end
   end

   // ==========================================================
   // architectural registers
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         flags_out <= cirs_pkg::FLAGS_RST;
         ip_out <= cirs_pkg::IP_RST;
         code_seg_out <= cirs_pkg::CS_RST;
         data_seg_out <= cirs_pkg::SEG_RST;
         extra_seg_out <= cirs_pkg::SEG_RST;
         stack_seg_out <= cirs_pkg::SEG_RST;
      end else if (state_q == cirs_pkg::CIRS_LOAD) begin
         ip_out <= handler_ip_in;
         code_seg_out <= handler_cs_in;
         flags_out[9] <= 1'b0;
         flags_out[8] <= 1'b0;
      end
   end

   // upper address lines stay high from reset until the first handler load
   logic addr_top_q;
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         addr_top_q <= 1'b1;
      end else if (state_q == cirs_pkg::CIRS_LOAD) begin
         addr_top_q <= 1'b0;
      end
   end
   logic [23:0] addr_top;
   assign addr_top = addr_top_q ? (cirs_pkg::START_ADDR & 24'hf00000) : 24'h000000;
   assign fetch_addr_out = ({4'h0, code_seg_out, 4'h0} + {8'h00, ip_out}) | addr_top;

   // ==========================================================
   // machine status word
   logic [3:0] msw_q;
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         msw_q <= cirs_pkg::MSW_RST[3:0];
      end else begin
         if (load_status_word_instr_in) begin
            msw_q <= status_wdata_in[3:0];
            msw_q[cirs_pkg::MSW_PE] <= status_wdata_in[cirs_pkg::MSW_PE] |
                                       msw_q[cirs_pkg::MSW_PE];
         end
         if (task_switch_in) begin
            msw_q[cirs_pkg::MSW_TS] <= 1'b1;
         end
      end
   end
   assign machine_status_word_out = (cirs_pkg::MSW_RST & ~cirs_pkg::MSW_USED) |
                                    {12'h000, msw_q};
   assign status_rdata_out = store_status_word_instr_in ? machine_status_word_out
                                                        : 16'h0000;
   assign protected_mode_out = msw_q[cirs_pkg::MSW_PE];

   // coprocessor trap to vector 7; all clear gives none
   assign coproc_trap_out = (coproc_escape_op_in && msw_q[cirs_pkg::MSW_EM]) ||
                            (wait_op_in && msw_q[cirs_pkg::MSW_MP] &&
                             msw_q[cirs_pkg::MSW_TS]) ||
                            (coproc_escape_op_in && msw_q[cirs_pkg::MSW_TS]);

   // ==========================================================
   // hold window after reset
   logic [5:0] hold_cnt_q;
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         hold_cnt_q <= 6'h00;
      end else if (hold_cnt_q != 6'(cirs_pkg::HOLD_BLOCK_CLKS)) begin
         hold_cnt_q <= hold_cnt_q + 6'h01;
      end
   end
   assign hold_blocked_out = hold_cnt_q != 6'(cirs_pkg::HOLD_BLOCK_CLKS);

   // ==========================================================
   // checks
   sequence s_push3;
      push_valid_out ##1 push_valid_out ##1 push_valid_out;
   endsequence

   chk_push_then_load: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (state_q == cirs_pkg::CIRS_PUSH_FLAGS) |=> s_push3 ##0 accept_out)
      else $error("push sequence broken");
   chk_prio_order: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (grant[cirs_pkg::SRC_STEP]) |-> !exc_req_in)
      else $error("priority order violated");
   chk_stack_first: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (accept_out && any_req) |=> !exec_en_out ##1 (state_q == cirs_pkg::CIRS_PUSH_FLAGS))
      else $error("pending request not stacked");
   chk_reset_state: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      $rose(rst_n) |-> ip_out == cirs_pkg::IP_RST && code_seg_out == cirs_pkg::CS_RST)
      else $error("reset values wrong");
   chk_pe_sticky: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      protected_mode_out |=> protected_mode_out)
      else $error("protect enable cleared");
   chk_ts_record: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      task_switch_in |=> machine_status_word_out[cirs_pkg::MSW_TS])
      else $error("task switch not recorded");
   chk_em_trap: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (coproc_escape_op_in && machine_status_word_out[cirs_pkg::MSW_EM]) |-> coproc_trap_out)
      else $error("emulation trap missing");
   chk_legacy_quiet: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (msw_q[3:1] == 3'b000) |-> !coproc_trap_out)
      else $error("trap with coprocessor bits clear");
   chk_boundary_only: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (state_q == cirs_pkg::CIRS_RUN && !insn_boundary_in && !stacking_q)
      |=> state_q != cirs_pkg::CIRS_PUSH_FLAGS)
      else $error("accept off boundary");
   chk_start_addr: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (state_q == cirs_pkg::CIRS_STARTUP) |-> fetch_addr_out == cirs_pkg::START_ADDR)
      else $error("start address wrong");
   chk_msw_upper: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      machine_status_word_out[15:4] == 12'hfff)
      else $error("status word upper bits wrong");
   chk_store_idle: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      !store_status_word_instr_in |-> status_rdata_out == 16'h0000)
      else $error("store data without store");
   chk_mp_trap: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (wait_op_in && msw_q[cirs_pkg::MSW_MP] && msw_q[cirs_pkg::MSW_TS]) |-> coproc_trap_out)
      else $error("monitor trap missing");
   chk_ts_trap: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (coproc_escape_op_in && msw_q[cirs_pkg::MSW_TS]) |-> coproc_trap_out)
      else $error("task-switched trap missing");
   chk_hold_release: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      $rose(rst_n) |-> hold_blocked_out)
      else $error("hold window not open after reset");
   chk_no_exec_startup: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
      (state_q == cirs_pkg::CIRS_STARTUP) |-> !exec_en_out && !push_valid_out)
      else $error("activity during start-up");
endmodule

// [cirs_partner.sv]
// far side model: reset source, bus-hold requester and maskable interrupt controller
`timescale 1ns/1ps
module cirs_partner (
   input wire logic clk_in,
   input wire logic rst_req_in,
   input wire logic irq_raise_in,
   input wire logic accept_in,
   input wire logic [5:0] accept_src_in,
   output logic reset_n_out,
   output logic maskable_irq_out,
   output logic [7:0] irq_vec_out,
   output logic hold_req_out,
   output logic [7:0] hold_wait_out
);
   // ==========================================================
   // reset source and hold requester
   assign reset_n_out = ~rst_req_in;
   always_ff @(posedge clk_in or negedge reset_n_out) begin
      if (!reset_n_out) begin
         hold_wait_out <= 8'h00;
      end else if (hold_wait_out != 8'hff) begin
         hold_wait_out <= hold_wait_out + 8'h01;
      end
   end
   // hold stays quiet from reset until 34 clocks after release
   assign hold_req_out = (hold_wait_out >= 8'h22);
   // ==========================================================
   // interrupt controller: level request, dropped once taken
   always_ff @(posedge clk_in or negedge reset_n_out) begin
      if (!reset_n_out) begin
         maskable_irq_out <= 1'b0;
      end else if (accept_in && accept_src_in[4]) begin
         maskable_irq_out <= 1'b0;
      end else if (irq_raise_in) begin
         maskable_irq_out <= 1'b1;
      end
   end
   // vector only meaningful while requesting
   assign irq_vec_out = maskable_irq_out ? 8'h40 : 8'hbf;
endmodule

// [test_cirs_core.sv]
// testbench for the interrupt sequencing, reset state and status word block
`timescale 1ns/1ps
module test_cirs_core;
   logic sys_clk, rst_req, boundary, coproc_escape_op, wt, ld, st, tsw, irq_raise;
   logic [5:0] req;
   logic [15:0] wdata, flags, ip, cs, ds, es, ss, machine_status_word, rdata, push_data;
   logic pm, exec_en, push_valid, accept, trap, hold_blocked, reset_n, irq, hold_req;
   logic [23:0] fetch;
   logic [7:0] acc_vec, irq_vec, hold_wait;
   logic [5:0] acc_src;
   logic [7:0] vec_tab [6] = '{8'h06, 8'h01, 8'h02, 8'h09, 8'h40, 8'h80};
   int n_errors = 0;
   int compares = 0;
   int k;
   // ==========================================================
   // clock, partner and design
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   cirs_partner i_partner (.clk_in(sys_clk), .rst_req_in(rst_req), .irq_raise_in(irq_raise),
      .accept_in(accept), .accept_src_in(acc_src), .reset_n_out(reset_n),
      .maskable_irq_out(irq), .irq_vec_out(irq_vec), .hold_req_out(hold_req),
      .hold_wait_out(hold_wait));
   cirs_core i_dut (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .insn_boundary_in(boundary),
      .exc_req_in(req[0]), .exc_vec_in(8'h06), .step_req_in(req[1]), .nmi_req_in(req[2]),
      .ovr_req_in(req[3]), .maskable_irq_in(irq), .irq_vec_in(irq_vec), .swi_req_in(req[5]),
      .swi_vec_in(8'h80), .coproc_escape_op_in(coproc_escape_op), .wait_op_in(wt),
      .load_status_word_instr_in(ld), .status_wdata_in(wdata),
      .store_status_word_instr_in(st), .task_switch_in(tsw), .handler_ip_in(16'h5678),
      .handler_cs_in(16'h1234), .flags_out(flags), .ip_out(ip), .code_seg_out(cs),
      .data_seg_out(ds), .extra_seg_out(es), .stack_seg_out(ss),
      .machine_status_word_out(machine_status_word), .status_rdata_out(rdata), .protected_mode_out(pm),
      .exec_en_out(exec_en), .fetch_addr_out(fetch), .push_valid_out(push_valid),
      .push_data_out(push_data), .accept_out(accept), .accept_vec_out(acc_vec),
      .accept_src_out(acc_src), .coproc_trap_out(trap), .hold_blocked_out(hold_blocked));
   // ==========================================================
   // shared tasks
   task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic timed_out(input string name);
      n_errors++;
      $display("MISMATCH %s expected event seen none", name);
      stop_test();
   endtask
   task automatic load_msw(input logic [15:0] w);
      wdata = w;
      ld = 1'b1;
      @(negedge sys_clk);
      ld = 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic check_reset();
      chk("flags", 24'h0002, flags);
      chk("ip", 24'hfff0, ip);
      chk("cs", 24'hf000, cs);
      chk("ds_es_ss", 24'h0, ds | es | ss);
      chk("msw", 24'hfff0, machine_status_word);
      chk("protected", 24'h0, pm);
      chk("exec_en", 24'h0, exec_en);
      chk("hold_req_quiet", 24'h0, hold_req);
   endtask
   task automatic reset_and_start();
      rst_req = 1'b1;
      repeat (3) @(negedge sys_clk);
      check_reset();
      rst_req = 1'b0;
      for (k = 0; k < 12 && exec_en !== 1'b1; k++) @(negedge sys_clk);
      if (k == 12) timed_out("exec_en");
      chk("fetch_addr", 24'hfffff0, fetch);
      chk("msw_start", 24'hfff0, machine_status_word);
   endtask
   task automatic take(input int idx, input logic [15:0] rcs, input logic [15:0] rip);
      logic [15:0] pushed [3];
      int n;
      int j;
      n = 0;
      for (j = 0; j < 30; j++) begin
         @(negedge sys_clk);
         if (push_valid === 1'b1 && n < 3) begin
            pushed[n] = push_data;
            n++;
         end
         if (accept === 1'b1) break;
      end
      if (j == 30) timed_out("accept");
      chk("accept_src", 24'h1 << idx, acc_src);
      chk("accept_vec", vec_tab[idx], acc_vec);
      chk("exec_en_stack", 24'h0, exec_en);
      chk("push_count", 24'h3, 24'(n));
      chk("push_flags", 24'h0002, pushed[0]);
      chk("push_cs", rcs, pushed[1]);
      chk("push_ip", rip, pushed[2]);
      req[idx] = 1'b0;
   endtask
   // ==========================================================
   // main sequence
   initial begin
      {rst_req, boundary, coproc_escape_op, wt, ld, st, tsw, irq_raise} = 8'h80;
      req = 6'h00;
      wdata = 16'h0000;
      @(negedge sys_clk);
      reset_and_start();
      for (k = 0; k < 40 && hold_wait < 8'h22; k++) @(negedge sys_clk);
      chk("hold_blocked_34", 24'h1, hold_blocked);
      for (k = 0; k < 8 && hold_blocked !== 1'b0; k++) @(negedge sys_clk);
      chk("hold_blocked_end", 24'h0, hold_blocked);
      // coprocessor trap encodings over monitor, emulation, task-switched
      for (int m = 0; m < 8; m++) begin
         load_msw(16'(m) << 1);
         chk("msw_load", 24'hfff0 | (m << 1), machine_status_word);
         st = 1'b1;
         @(negedge sys_clk);
         chk("store_rdata", 24'hfff0 | (m << 1), rdata);
         st = 1'b0;
         coproc_escape_op = 1'b1;
         @(negedge sys_clk);
         chk("trap_escape", 24'(m[1] | m[2]), trap);
         coproc_escape_op = 1'b0;
         wt = 1'b1;
         @(negedge sys_clk);
         chk("trap_wait", 24'(m[0] & m[2]), trap);
         wt = 1'b0;
      end
      load_msw(16'h0000);
      tsw = 1'b1;
      @(negedge sys_clk);
      tsw = 1'b0;
      @(negedge sys_clk);
      chk("msw_task_switch", 24'hfff8, machine_status_word);
      load_msw(16'h0000);
      // requests off a boundary are not taken
      req[2] = 1'b1;
      irq_raise = 1'b1;
      for (k = 0; k < 8; k++) begin
         @(negedge sys_clk);
         chk("accept_off_boundary", 24'h0, accept);
      end
      req = 6'h2f;
      boundary = 1'b1;
      take(0, 16'hf000, 16'hfff0);
      foreach (vec_tab[i]) if (i > 0 && i != 4) take(i, 16'h1234, 16'h5678);
      @(negedge sys_clk);
      @(negedge sys_clk);
      chk("handler_ip", 24'h5678, ip);
      chk("handler_cs", 24'h1234, cs);
      chk("handler_fetch", 24'h0179b8, fetch);
      for (k = 0; k < 10; k++) begin
         @(negedge sys_clk);
         chk("maskable_refused", 24'h0, accept);
      end
      irq_raise = 1'b0;
      boundary = 1'b0;
      load_msw(16'h0001);
      chk("protected_set", 24'h1, pm);
      load_msw(16'h0000);
      chk("protected_kept", 24'h1, pm);
      chk("msw_pe_kept", 24'hfff1, machine_status_word);
      reset_and_start();
      stop_test();
   end
endmodule
